// File: inc/supervision_pkg.sv
// Constants, register map and reset values of the valve positioner
// supervision block. Assumes 0.1 % units for positions and set points.
package supervision_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICKS_PER_S_DEF = 1000 / TICK_PERIOD_MS;
  localparam int NV_SAVE_HOURS = 24;
  localparam int NV_SAVE_S_DEF = NV_SAVE_HOURS * 3600;

  localparam logic [15:0] RANGE = 16'h03E8;
  localparam logic [15:0] LIMIT_OFF = 16'hFFFF;
  localparam logic [31:0] TOTAL_MAX = 32'h3B02_3380;
  localparam logic [31:0] EXPO_FROM = 32'h0000_270F;
  localparam logic [31:0] TRAVEL_LIMIT_MIN = 32'h0000_03E8;
  localparam logic [7:0] TRANSIT_MAX = 8'hF0;
  localparam logic [3:0] CHAR_MAX = 4'h9;
  localparam logic [7:0] ERR_LOOP_CODE = 8'h39;

  localparam logic [3:0] REG_TOL = 4'h0;
  localparam logic [3:0] REG_LAG = 4'h1;
  localparam logic [3:0] REG_CHAR = 4'h2;
  localparam logic [3:0] REG_OPEN_T = 4'h3;
  localparam logic [3:0] REG_CLOSE_T = 4'h4;
  localparam logic [3:0] REG_CLOSE_CUT = 4'h5;
  localparam logic [3:0] REG_OPEN_CUT = 4'h6;
  localparam logic [3:0] REG_TRAVEL_LIM = 4'h7;
  localparam logic [3:0] REG_CLASS = 4'h8;
  localparam logic [3:0] REG_ALARM_MODE = 4'h9;
  localparam logic [3:0] REG_LIMIT1 = 4'hA;
  localparam logic [3:0] REG_LIMIT2 = 4'hB;
  localparam logic [3:0] REG_TOTAL = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'hD;
  localparam logic [3:0] REG_NV_SAVED = 4'hE;

  localparam logic [15:0] TOL_RST = 16'h0032;
  localparam logic [15:0] LAG_RST = 16'h001E;
  localparam logic [3:0] CHAR_RST = 4'h0;
  localparam logic [7:0] TRANSIT_RST = 8'h00;
  localparam logic [15:0] CLOSE_CUT_RST = 16'h000A;
  localparam logic [15:0] OPEN_CUT_RST = LIMIT_OFF;
  localparam logic [31:0] TRAVEL_LIM_RST = 32'h000F_4240;
  localparam logic [1:0] CLASS_MAINT = 2'h1;
  localparam logic [1:0] ALARM_MODE_RST = 2'h2;
  localparam logic [15:0] LIMIT1_RST = 16'h0014;
  localparam logic [15:0] LIMIT2_RST = 16'h0384;

  localparam int PIN_FAILSAFE = 0;
  localparam int PIN_SOLENOID = 1;
  localparam int PIN_VENT = 2;
  localparam int PIN_AUX_FAIL = 3;
  localparam int PIN_INDUCTIVE = 4;
  localparam int PIN_COUNT = 5;

  localparam int ST_LOOP_ERR = 0;
  localparam int ST_EXCEEDED = 1;
  localparam int ST_EXPO = 2;
  localparam int ST_TIGHT = 3;
  localparam int ST_FULL_OPEN = 4;
  localparam int ST_ALARM1 = 5;
  localparam int ST_ALARM2 = 6;
  localparam int ST_BYPASS = 7;
  localparam int ST_LIM_EXPO = 8;
endpackage

// File: hdl/nv_store.sv
// Non-volatile image of the travel totalizer, one word wide.
// Assumes the write strobe is a one-cycle pulse from the same clock.
`timescale 1ns/100ps
module nv_store #(
  parameter int WIDTH = 32
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic write_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] word_r;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_r <= '0;
    end else if (write_in) begin
      word_r <= data_in;
    end
  end

  assign data_out = word_r;
endmodule

// File: hdl/valve_positioner_supervision.sv
// Supervision and set-point shaping of a valve positioner.
// Assumes set point, position, cycle pulses and minimum transit times come
// from logic on clock_in; fail-safe style inputs are asynchronous pins.
`timescale 1ns/100ps
module valve_positioner_supervision #(
  parameter int TICK_CYCLES = supervision_pkg::TICK_CYCLES_DEF,
  parameter int TICKS_PER_S = supervision_pkg::TICKS_PER_S_DEF,
  parameter int NV_SAVE_S = supervision_pkg::NV_SAVE_S_DEF
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic op_software_in,
  output logic [31:0] rdata_out,
  input wire logic [15:0] setpoint_in,
  input wire logic [15:0] position_in,
  input wire logic [7:0] min_open_s_in,
  input wire logic [7:0] min_close_s_in,
  input wire logic cycle_done_in,
  input wire logic initialized_in,
  input wire logic [4:0] pins_in,
  output logic [15:0] ramped_setpoint_out,
  output logic loop_error_out,
  output logic [7:0] error_code_out,
  output logic [3:0] char_sel_out,
  output logic tight_close_out,
  output logic full_open_out,
  output logic travel_exceeded_out,
  output logic [1:0] travel_class_out,
  output logic alarm_one_out,
  output logic alarm_two_out,
  output logic nv_write_out
);
  logic [4:0] s1_r, s2_r, s3_r, pin_r;
  logic [31:0] tick_cnt_r, sub_cnt_r, sec_cnt_r, lag_cnt_r, acc_r;
  logic tick_r, sec_r, nv_we_r;
  logic [15:0] tol_r, lag_r, close_cut_r, open_cut_r, limit1_r, limit2_r;
  logic [15:0] sp_r;
  logic [3:0] char_r;
  logic [7:0] open_t_r, close_t_r;
  logic [31:0] travel_lim_r, total_r, total_nxt, nv_word;
  logic [1:0] class_r, alarm_mode_r;
  logic loop_err_r, tight_r, full_open_r, exceeded_r, a1_r, a2_r;
  logic [31:0] rdata_r;
  logic [7:0] err_code_r;
  logic wr_ok, clear_total, bypass, dev_over, opening, step;
  logic [31:0] lag_ticks, ramp_ticks, acc_sum;

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // Zero keeps the ramp off; otherwise never faster than the actuator
  function automatic logic [31:0] ramp_len(input logic [7:0] cfg,
                                           input logic [7:0] act);
    logic [7:0] s;
    s = (cfg > act) ? cfg : act;
    ramp_len = (cfg == 8'h00) ? 32'h0 : 32'(s) * 32'(TICKS_PER_S);
  endfunction

  // A pin level counts once the second and third stages agree
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s3_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      sub_cnt_r <= '0;
      sec_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? '0 :
                    tick_cnt_r + 32'h1;
      sec_r <= tick_r && (sub_cnt_r == 32'(TICKS_PER_S - 1));
      if (tick_r) begin
        sub_cnt_r <= (sub_cnt_r == 32'(TICKS_PER_S - 1)) ? '0 :
                     sub_cnt_r + 32'h1;
      end
    end
  end

  assign wr_ok = wr_in && op_software_in;
  assign clear_total = wr_in && (addr_in == supervision_pkg::REG_TOTAL);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tol_r <= supervision_pkg::TOL_RST;
      lag_r <= supervision_pkg::LAG_RST;
      char_r <= supervision_pkg::CHAR_RST;
      open_t_r <= supervision_pkg::TRANSIT_RST;
      close_t_r <= supervision_pkg::TRANSIT_RST;
      close_cut_r <= supervision_pkg::CLOSE_CUT_RST;
      open_cut_r <= supervision_pkg::OPEN_CUT_RST;
      travel_lim_r <= supervision_pkg::TRAVEL_LIM_RST;
      class_r <= supervision_pkg::CLASS_MAINT;
      alarm_mode_r <= supervision_pkg::ALARM_MODE_RST;
      limit1_r <= supervision_pkg::LIMIT1_RST;
      limit2_r <= supervision_pkg::LIMIT2_RST;
    end else if (wr_in) begin
      // Out-of-range selector, transit time, travel limit and limit one values are dropped, the old setting stays
      if (addr_in == supervision_pkg::REG_TOL) begin
        tol_r <= wdata_in[15:0];
      end else if (addr_in == supervision_pkg::REG_LAG) begin
        if (wr_ok) lag_r <= wdata_in[15:0];
      end else if (addr_in == supervision_pkg::REG_CHAR) begin
        if (wdata_in[31:0] <= 32'(supervision_pkg::CHAR_MAX))
          char_r <= wdata_in[3:0];
      end else if (addr_in == supervision_pkg::REG_OPEN_T) begin
        if (wdata_in[31:0] <= 32'(supervision_pkg::TRANSIT_MAX))
          open_t_r <= wdata_in[7:0];
      end else if (addr_in == supervision_pkg::REG_CLOSE_T) begin
        if (wdata_in[31:0] <= 32'(supervision_pkg::TRANSIT_MAX))
          close_t_r <= wdata_in[7:0];
      end else if (addr_in == supervision_pkg::REG_CLOSE_CUT) begin
        close_cut_r <= wdata_in[15:0];
      end else if (addr_in == supervision_pkg::REG_OPEN_CUT) begin
        open_cut_r <= wdata_in[15:0];
      end else if (addr_in == supervision_pkg::REG_TRAVEL_LIM) begin
        if (wdata_in >= supervision_pkg::TRAVEL_LIMIT_MIN &&
            wdata_in <= supervision_pkg::TOTAL_MAX)
          travel_lim_r <= wdata_in;
      end else if (addr_in == supervision_pkg::REG_CLASS) begin
        if (wr_ok) class_r <= wdata_in[1:0];
      end else if (addr_in == supervision_pkg::REG_ALARM_MODE) begin
        alarm_mode_r <= wdata_in[1:0];
      end else if (addr_in == supervision_pkg::REG_LIMIT1) begin
        if (wdata_in[15:0] <= supervision_pkg::RANGE ||
            wdata_in[15:0] == supervision_pkg::LIMIT_OFF)
          limit1_r <= wdata_in[15:0];
      end else if (addr_in == supervision_pkg::REG_LIMIT2) begin
        limit2_r <= wdata_in[15:0];
      end
    end
  end

  // Tolerance monitor watches the shaped set point against position
  assign dev_over = abs_diff(sp_r, position_in) > tol_r;
  assign lag_ticks = 32'(lag_r) * 32'(TICKS_PER_S);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lag_cnt_r <= '0;
      loop_err_r <= 1'b0;
      err_code_r <= 8'h00;
    end else begin
      if (!dev_over) begin
        lag_cnt_r <= '0;
      end else if (tick_r && lag_cnt_r != 32'hFFFF_FFFF) begin
        lag_cnt_r <= lag_cnt_r + 32'h1;
      end
      loop_err_r <= dev_over && (lag_cnt_r > lag_ticks);
      err_code_r <= (dev_over && (lag_cnt_r > lag_ticks)) ?
                    supervision_pkg::ERR_LOOP_CODE : 8'h00;
    end
  end

  assign bypass = pin_r[supervision_pkg::PIN_FAILSAFE] |
                  pin_r[supervision_pkg::PIN_SOLENOID] |
                  pin_r[supervision_pkg::PIN_VENT] |
                  pin_r[supervision_pkg::PIN_AUX_FAIL];
  assign opening = setpoint_in > sp_r;
  assign ramp_ticks = opening ? ramp_len(open_t_r, min_open_s_in) :
                      ramp_len(close_t_r, min_close_s_in);
  assign acc_sum = acc_r + 32'(supervision_pkg::RANGE);
  assign step = tick_r && (acc_sum >= ramp_ticks);

  // One unit per step; a step never exceeds one unit since the range
  // is never longer than one second of ticks
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sp_r <= '0;
      acc_r <= '0;
    end else if (bypass || ramp_ticks == 32'h0) begin
      sp_r <= setpoint_in;
      acc_r <= '0;
    end else if (setpoint_in == sp_r) begin
      acc_r <= '0;
    end else if (tick_r) begin
      acc_r <= step ? acc_sum - ramp_ticks : acc_sum;
      if (step) begin
        sp_r <= opening ? sp_r + 16'h1 : sp_r - 16'h1;
      end
    end
  end

  // Cutoffs act on the ramped set point, so a running ramp wins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tight_r <= 1'b0;
      full_open_r <= 1'b0;
    end else begin
      tight_r <= (close_cut_r != supervision_pkg::LIMIT_OFF) &&
                 (sp_r < close_cut_r);
      full_open_r <= (open_cut_r != supervision_pkg::LIMIT_OFF) &&
                     (sp_r > open_cut_r);
    end
  end

  // A cycle arriving with the clear is still counted
  always_comb begin
    total_nxt = clear_total ? 32'h0 : total_r;
    if (cycle_done_in && total_nxt < supervision_pkg::TOTAL_MAX) begin
      total_nxt = total_nxt + 32'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      total_r <= '0;
      exceeded_r <= 1'b0;
    end else begin
      total_r <= total_nxt;
      exceeded_r <= total_r > travel_lim_r;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec_cnt_r <= '0;
      nv_we_r <= 1'b0;
    end else begin
      nv_we_r <= sec_r && (sec_cnt_r == 32'(NV_SAVE_S - 1));
      if (sec_r) begin
        sec_cnt_r <= (sec_cnt_r == 32'(NV_SAVE_S - 1)) ? '0 :
                     sec_cnt_r + 32'h1;
      end
    end
  end

  nv_store #(.WIDTH(32)) nv_store_u (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .write_in(nv_we_r),
    .data_in(total_r),
    .data_out(nv_word)
  );

  // Mode bit 0 and bit 1 give the switching sense of each alarm
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      a1_r <= 1'b0;
      a2_r <= 1'b0;
    end else if (!initialized_in) begin
      a1_r <= 1'b0;
      a2_r <= 1'b0;
    end else begin
      a1_r <= alarm_mode_r[0] ^
              (!pin_r[supervision_pkg::PIN_INDUCTIVE] &&
               limit1_r != supervision_pkg::LIMIT_OFF &&
               position_in < limit1_r);
      a2_r <= alarm_mode_r[1] ^
              (limit2_r != supervision_pkg::LIMIT_OFF &&
               position_in < limit2_r);
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else if (!rd_in) begin
      rdata_r <= '0;
    end else if (addr_in == supervision_pkg::REG_TOL) begin
      rdata_r <= 32'(tol_r);
    end else if (addr_in == supervision_pkg::REG_LAG) begin
      rdata_r <= 32'(lag_r);
    end else if (addr_in == supervision_pkg::REG_CHAR) begin
      rdata_r <= 32'(char_r);
    end else if (addr_in == supervision_pkg::REG_OPEN_T) begin
      rdata_r <= 32'(open_t_r);
    end else if (addr_in == supervision_pkg::REG_CLOSE_T) begin
      rdata_r <= 32'(close_t_r);
    end else if (addr_in == supervision_pkg::REG_CLOSE_CUT) begin
      rdata_r <= 32'(close_cut_r);
    end else if (addr_in == supervision_pkg::REG_OPEN_CUT) begin
      rdata_r <= 32'(open_cut_r);
    end else if (addr_in == supervision_pkg::REG_TRAVEL_LIM) begin
      rdata_r <= travel_lim_r;
    end else if (addr_in == supervision_pkg::REG_CLASS) begin
      rdata_r <= 32'(class_r);
    end else if (addr_in == supervision_pkg::REG_ALARM_MODE) begin
      rdata_r <= 32'(alarm_mode_r);
    end else if (addr_in == supervision_pkg::REG_LIMIT1) begin
      rdata_r <= 32'(limit1_r);
    end else if (addr_in == supervision_pkg::REG_LIMIT2) begin
      rdata_r <= 32'(limit2_r);
    end else if (addr_in == supervision_pkg::REG_TOTAL) begin
      rdata_r <= total_r;
    end else if (addr_in == supervision_pkg::REG_STATUS) begin
      rdata_r <= {8'h00, loop_err_r ? supervision_pkg::ERR_LOOP_CODE :
                  8'h00, 7'h00,
                  travel_lim_r >= supervision_pkg::EXPO_FROM, bypass,
                  a2_r, a1_r, full_open_r, tight_r,
                  total_r >= supervision_pkg::EXPO_FROM,
                  exceeded_r, loop_err_r};
    end else if (addr_in == supervision_pkg::REG_NV_SAVED) begin
      rdata_r <= nv_word;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;
  assign ramped_setpoint_out = sp_r;
  assign loop_error_out = loop_err_r;
  assign error_code_out = err_code_r;
  assign char_sel_out = char_r;
  assign tight_close_out = tight_r;
  assign full_open_out = full_open_r;
  assign travel_exceeded_out = exceeded_r;
  assign travel_class_out = class_r;
  assign alarm_one_out = a1_r;
  assign alarm_two_out = a2_r;
  assign nv_write_out = nv_we_r;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  loop_err_cause_a: assert property (
    !dev_over |=> !loop_err_r) else $error("loop error without deviation");
  lag_locked_a: assert property (
    wr_in && !op_software_in && addr_in == supervision_pkg::REG_LAG
    |=> $stable(lag_r)) else $error("lag time changed locally");
  char_range_a: assert property (
    char_r <= supervision_pkg::CHAR_MAX) else $error("bad selector");
  transit_range_a: assert property (
    open_t_r <= supervision_pkg::TRANSIT_MAX &&
    close_t_r <= supervision_pkg::TRANSIT_MAX)
    else $error("transit time out of range");
  ramp_bypass_a: assert property (
    bypass |=> sp_r == $past(setpoint_in))
    else $error("ramp not bypassed");
  ramp_step_a: assert property (
    !bypass && ramp_ticks != 32'h0 |=> abs_diff(sp_r, $past(sp_r)) <= 16'h1)
    else $error("ramp step too large");
  total_clear_a: assert property (
    clear_total && !cycle_done_in |=> total_r == 32'h0)
    else $error("totalizer not cleared");
  total_count_a: assert property (
    !clear_total && cycle_done_in && total_r < supervision_pkg::TOTAL_MAX
    |=> total_r == $past(total_r) + 32'h1)
    else $error("cycle not counted");
  nv_save_a: assert property (
    nv_we_r |=> nv_word == $past(total_r))
    else $error("save not taken");
  limit_floor_a: assert property (
    travel_lim_r >= supervision_pkg::TRAVEL_LIMIT_MIN)
    else $error("travel limit below floor");
  class_locked_a: assert property (
    wr_in && !op_software_in && addr_in == supervision_pkg::REG_CLASS
    |=> $stable(class_r)) else $error("class changed locally");
  alarm_init_a: assert property (
    !initialized_in |=> !a1_r && !a2_r)
    else $error("alarm before initialization");
  inductive_a: assert property (
    initialized_in && pin_r[supervision_pkg::PIN_INDUCTIVE]
    |=> a1_r == $past(alarm_mode_r[0]))
    else $error("alarm one not ignored");
  tight_close_a: assert property (
    close_cut_r != supervision_pkg::LIMIT_OFF && sp_r < close_cut_r
    |=> tight_r) else $error("tight closing missing");

  ramp_run_c: cover property (!bypass && step ##1 sp_r != $past(sp_r));
  loop_err_c: cover property ($rose(loop_err_r));
  exceeded_c: cover property ($rose(exceeded_r));
  nv_save_c: cover property (nv_we_r);
endmodule

// File: tb/actuator_model.sv
// Actuator and valve model: the stem slews toward the shaped set point.
// Assumes the block's clock; stuck_in models a jammed valve stem.
`timescale 1ns/100ps
module actuator_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic stuck_in,
  input wire logic [15:0] setpoint_in,
  output logic [15:0] position_out
);
  // One unit per clock keeps travel short against the monitor lag
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      position_out <= 16'h0000;
    end else if (!stuck_in && position_out < setpoint_in) begin
      position_out <= position_out + 16'h0001;
    end else if (!stuck_in && position_out > setpoint_in) begin
      position_out <= position_out - 16'h0001;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the positioner supervision block.
// Assumes shortened timing: 4 clocks a tick, 1000 ticks a second.
`timescale 1ns/100ps
module tb_top;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sw = 1'b0;
  logic cyc = 1'b0;
  logic init = 1'b0;
  logic stuck = 1'b0;
  logic [15:0] sp = 16'h0000;
  logic [7:0] mino = 8'h00;
  logic [7:0] minc = 8'h00;
  logic [4:0] pins = 5'h00;
  logic [31:0] rdata, d;
  logic [15:0] rsp, pos;
  logic lerr, tight, fopen, exc, a1, a2, nvw;
  logic [7:0] ecode;
  logic [3:0] chr;
  logic [1:0] cls;
  int bad_count = 0;
  int checks = 0;
  int n;
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  valve_positioner_supervision #(.TICK_CYCLES(4), .TICKS_PER_S(1000),
      .NV_SAVE_S(2)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .op_software_in(sw), .rdata_out(rdata), .setpoint_in(sp),
      .position_in(pos), .min_open_s_in(mino), .min_close_s_in(minc),
      .cycle_done_in(cyc), .initialized_in(init), .pins_in(pins),
      .ramped_setpoint_out(rsp), .loop_error_out(lerr),
      .error_code_out(ecode), .char_sel_out(chr), .tight_close_out(tight),
      .full_open_out(fopen), .travel_exceeded_out(exc),
      .travel_class_out(cls), .alarm_one_out(a1), .alarm_two_out(a2),
      .nv_write_out(nvw));
  actuator_model i_act (.clock_in(clock_in), .rstn_in(rstn_in),
      .stuck_in(stuck), .setpoint_in(rsp), .position_out(pos));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h", $time, msg, got);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo,
      input logic [31:0] hi, input string msg);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0d", $time, msg, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v,
      input logic s);
    @(posedge clock_in);
    addr <= a;
    wdata <= v;
    sw <= s;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp,
      input string msg);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 d = rdata;
    chk(d, exp, msg);
  endtask
  task automatic pulses(input int c);
    repeat (c) begin
      @(posedge clock_in);
      cyc <= 1'b1;
      @(posedge clock_in);
      cyc <= 1'b0;
    end
    #1;
  endtask
  // A missing save pulse ends the run rather than hanging it
  task automatic wait_nv(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (nvw !== 1'b1 && c < 9000);
    if (c >= 9000) begin
      bad_count++;
      $display("unexpected at %0t: no save pulse", $time);
      give_verdict();
    end
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    rchk(supervision_pkg::REG_TOL, 32'h32, "tol");
    rchk(supervision_pkg::REG_LAG, 32'h1E, "lag");
    rchk(supervision_pkg::REG_CHAR, 32'h0, "char");
    rchk(supervision_pkg::REG_CLASS, 32'h1, "class");
    rchk(supervision_pkg::REG_ALARM_MODE, 32'h2, "mode");
    rchk(supervision_pkg::REG_LIMIT1, 32'h14, "limit one");
    rchk(4'hF, 32'h0, "unmapped");
    $display("test reset values done");
    wr_reg(supervision_pkg::REG_LAG, 32'h1, 1'b0);
    rchk(supervision_pkg::REG_LAG, 32'h1E, "local lag");
    wr_reg(supervision_pkg::REG_LAG, 32'h1, 1'b1);
    rchk(supervision_pkg::REG_LAG, 32'h1, "soft lag");
    wr_reg(supervision_pkg::REG_CLASS, 32'h2, 1'b0);
    chk(cls, 2'h1, "local class");
    wr_reg(supervision_pkg::REG_CLASS, 32'h2, 1'b1);
    chk(cls, 2'h2, "soft class");
    wr_reg(supervision_pkg::REG_CHAR, 32'h9, 1'b0);
    chk(chr, 4'h9, "char 9");
    wr_reg(supervision_pkg::REG_CHAR, 32'hA, 1'b0);
    chk(chr, 4'h9, "char 10");
    wr_reg(supervision_pkg::REG_LIMIT1, 32'h3E9, 1'b0);
    rchk(supervision_pkg::REG_LIMIT1, 32'h14, "limit one 1001");
    for (int r = 3; r < 5; r++) begin
      wr_reg(r[3:0], 32'hF1, 1'b0);
      rchk(r[3:0], 32'h0, "transit 241");
      wr_reg(r[3:0], 32'hF0, 1'b0);
      rchk(r[3:0], 32'hF0, "transit 240");
      wr_reg(r[3:0], 32'h0, 1'b0);
    end
    $display("test settings done");
    wr_reg(supervision_pkg::REG_TRAVEL_LIM, 32'h3E7, 1'b0);
    rchk(supervision_pkg::REG_TRAVEL_LIM, 32'hF4240, "lim 999");
    wr_reg(supervision_pkg::REG_TRAVEL_LIM, 32'h3E8, 1'b0);
    pulses(1000);
    rchk(supervision_pkg::REG_TOTAL, 32'h3E8, "total");
    chk(exc, 1'b0, "at limit");
    pulses(1);
    tick(1);
    chk(exc, 1'b1, "over limit");
    pulses(8997);
    rchk(supervision_pkg::REG_STATUS, 32'hA, "9998 plain");
    pulses(1);
    rchk(supervision_pkg::REG_STATUS, 32'hE, "9999 expo");
    wr_reg(supervision_pkg::REG_TOTAL, 32'h0, 1'b0);
    rchk(supervision_pkg::REG_TOTAL, 32'h0, "cleared");
    chk(exc, 1'b0, "cleared flag");
    pulses(5);
    wait_nv(n);
    wait_nv(n);
    chk_in(n, 7999, 8001, "save gap");
    rchk(supervision_pkg::REG_NV_SAVED, 32'h5, "saved");
    $display("test totalizer done");
    init <= 1'b1;
    stuck <= 1'b1;
    sp <= 16'h01F4;
    tick(3800);
    chk(lerr, 1'b0, "before lag");
    tick(400);
    chk(lerr, 1'b1, "after lag");
    chk(ecode, 8'h39, "code");
    stuck <= 1'b0;
    tick(600);
    chk(lerr, 1'b0, "settled");
    chk({a1, a2}, 2'b00, "mode 2 high");
    sp <= 16'h000A;
    tick(600);
    chk({a1, a2}, 2'b10, "mode 2 low");
    wr_reg(supervision_pkg::REG_ALARM_MODE, 32'h0, 1'b0);
    tick(1);
    chk({a1, a2}, 2'b11, "mode 0 low");
    wr_reg(supervision_pkg::REG_ALARM_MODE, 32'h3, 1'b0);
    tick(1);
    chk({a1, a2}, 2'b00, "mode 3 low");
    wr_reg(supervision_pkg::REG_ALARM_MODE, 32'h0, 1'b0);
    pins <= 5'h10;
    tick(8);
    chk(a1, 1'b0, "inductive");
    pins <= 5'h00;
    init <= 1'b0;
    tick(8);
    chk({a1, a2}, 2'b00, "uninit");
    init <= 1'b1;
    sp <= 16'h0005;
    tick(3);
    chk(tight, 1'b1, "below cut");
    sp <= 16'h000A;
    tick(3);
    chk(tight, 1'b0, "at cut");
    $display("test alarms done");
    wr_reg(supervision_pkg::REG_OPEN_T, 32'h1, 1'b0);
    sp <= 16'h006E;
    tick(200);
    chk_in(rsp, 58, 62, "open ramp");
    tick(300);
    chk(rsp, 16'h006E, "ramp end");
    mino <= 8'h02;
    sp <= 16'h00D2;
    tick(400);
    chk_in(rsp, 158, 162, "min open");
    for (int i = 0; i < 4; i++) begin
      pins <= 5'h01 << i;
      sp <= 16'(300 + 100 * i);
      tick(7);
      chk(rsp, sp, "bypass");
      pins <= 5'h00;
      // Let the filtered pin drop so each source is seen alone
      tick(8);
    end
    wr_reg(supervision_pkg::REG_CLOSE_T, 32'h1, 1'b0);
    sp <= 16'h01F4;
    tick(200);
    chk_in(rsp, 548, 552, "close ramp");
    tick(240);
    minc <= 8'h02;
    sp <= 16'h0190;
    tick(400);
    chk_in(rsp, 448, 452, "min close");
    tick(480);
    wr_reg(supervision_pkg::REG_OPEN_CUT, 32'h190, 1'b0);
    sp <= 16'h01A4;
    tick(2);
    chk(fopen, 1'b0, "ramp before cut");
    tick(80);
    chk(fopen, 1'b1, "ramp past cut");
    $display("test ramps done");
    give_verdict();
  end
endmodule
